/* rtl/perf_monitor_msi_config.sv */
`timescale 1ns/1ns
// Function
// - target location held in bits 51:2
// - bits above output width stored as zero
// - zero target sends no MSI, wired edge
// - config read-only while enable or ack set
// - payload, target, attributes unknown after reset
// - domain 01 behaves as 00
// - device memory kind forces outer domain
// - memory kind taken from bits 3:0
// - abort flag set on aborted MSI write
// - enable 0-to-1 clears abort, 1-to-0 keeps
// - abort reads zero without MSI, status read-only
// - no MSI support: target, payload and attribute registers read zero, writes to them ignored
// - selects choose secure or non-secure limits
// - monitor group in bits 23:16, reset zero
// - partition id in bits 15:0, reset zero
// - over-limit identifiers may be replaced
// - update flag set by software, cleared once no MSI request is pending
// - write during update is ignored
// - write without update flag is ignored
// - accepted value reads back at once
// - interrupt needs enable and enabled overflow
// - disable completes after all MSI writes finish
module perf_monitor_msi_config #(
   parameter bit          MSI_SUPPORTED      = 1'b1,
   parameter bit          PARTITIONING       = 1'b1,
   parameter int          OUT_PHYS_WIDTH     = 52,
   parameter int          NUM_COUNTERS       = 4,
   parameter int          MAX_OUTSTANDING    = 4,
   parameter logic [15:0] NS_PARTITION_LIMIT = 16'hffff,
   parameter logic [15:0] S_PARTITION_LIMIT  = 16'hffff,
   parameter logic [7:0]  NS_GROUP_LIMIT     = 8'hff,
   parameter logic [7:0]  S_GROUP_LIMIT      = 8'hff
) (
   input  wire logic                    ref_clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    reg_wr_i,
   input  wire logic                    reg_rd_i,
   input  wire logic [11:0]             reg_addr_i,
   input  wire logic [31:0]             reg_wdata_i,
   output logic [31:0]                  reg_rdata_o,
   output logic                         reg_rvalid_o,
   input  wire logic [NUM_COUNTERS-1:0] overflow_flag_i,
   input  wire logic [NUM_COUNTERS-1:0] counter_int_enable_i,
   input  wire logic                    msi_nonsecure_select_i,
   input  wire logic                    nonsecure_reg_access_i,
   output logic                         msi_req_o,
   output logic [63:0]                  msi_addr_o,
   output logic [31:0]                  msi_data_o,
   output logic [1:0]                   msi_domain_o,
   output logic [3:0]                   msi_kind_o,
   output logic                         msi_ns_o,
   output logic [15:0]                  msi_partition_o,
   output logic [7:0]                   msi_group_o,
   input  wire logic                    msi_ack_i,
   input  wire logic                    msi_done_i,
   input  wire logic                    msi_abort_i,
   output logic                         irq_edge_o
);
   // ****************************************************************
   // derived constants and checks
   // ****************************************************************
   localparam logic [63:0] ADDR_MASK = ((64'h1 << OUT_PHYS_WIDTH) - 64'h1)
                                       & msi_cfg_pkg::ADDR_FIELD;
   localparam logic [15:0] PART_MASK = PARTITIONING ?
      msi_cfg_pkg::id_mask(NS_PARTITION_LIMIT | S_PARTITION_LIMIT) : 16'h0000;
   localparam logic [15:0] GROUP_W16 = PARTITIONING ?
      msi_cfg_pkg::id_mask({8'h00, NS_GROUP_LIMIT | S_GROUP_LIMIT}) : 16'h0000;
   localparam logic [7:0]  GROUP_MASK = GROUP_W16[7:0];
   localparam int          CW = $clog2(MAX_OUTSTANDING + 1);
   localparam logic [CW-1:0] OUT_MAX = CW'(MAX_OUTSTANDING);

   initial begin
      if (OUT_PHYS_WIDTH < 33 || OUT_PHYS_WIDTH > 52 || NUM_COUNTERS < 1
          || MAX_OUTSTANDING < 1) begin
         $error("perf_monitor_msi_config: unsupported parameter value");
      end
   end

   // ****************************************************************
   // register write carrier and configuration words
   // ****************************************************************
   cfg_write_if bus ();
   assign bus.wr    = reg_wr_i;
   assign bus.addr  = reg_addr_i;
   assign bus.wdata = reg_wdata_i;

   logic            enable_reg;
   logic            ack_reg;
   logic            abort_reg;
   logic            pending_reg;
   logic [CW-1:0]   outst_reg;
   logic            lock;
   logic [31:0]     tgt_lo;
   logic [31:0]     tgt_hi;
   logic [31:0]     payload;
   logic [31:0]     attr;
   logic [31:0]     tag_image;
   logic            tag_pending;
   logic [15:0]     eff_part;
   logic [7:0]      eff_group;

   assign lock = enable_reg | ack_reg;

   guarded_word #(
      .OFFSET    (msi_cfg_pkg::TGT_LO_OFS),
      .KEEP_MASK (ADDR_MASK[31:0]),
      .PRESENT   (MSI_SUPPORTED)
   ) u_tgt_lo (
      .ref_clk_i (ref_clk_i),
      .bus       (bus),
      .lock_i    (lock),
      .value_o   (tgt_lo)
   );

   guarded_word #(
      .OFFSET    (msi_cfg_pkg::TGT_HI_OFS),
      .KEEP_MASK (ADDR_MASK[63:32]),
      .PRESENT   (MSI_SUPPORTED)
   ) u_tgt_hi (
      .ref_clk_i (ref_clk_i),
      .bus       (bus),
      .lock_i    (lock),
      .value_o   (tgt_hi)
   );

   guarded_word #(
      .OFFSET    (msi_cfg_pkg::PAYLOAD_OFS),
      .KEEP_MASK (msi_cfg_pkg::PAYLOAD_MASK),
      .PRESENT   (MSI_SUPPORTED)
   ) u_payload (
      .ref_clk_i (ref_clk_i),
      .bus       (bus),
      .lock_i    (lock),
      .value_o   (payload)
   );

   guarded_word #(
      .OFFSET    (msi_cfg_pkg::ATTR_OFS),
      .KEEP_MASK (msi_cfg_pkg::ATTR_MASK),
      .PRESENT   (MSI_SUPPORTED)
   ) u_attr (
      .ref_clk_i (ref_clk_i),
      .bus       (bus),
      .lock_i    (lock),
      .value_o   (attr)
   );

   msi_tag_update #(
      .PART_MASK  (PART_MASK),
      .GROUP_MASK (GROUP_MASK)
   ) u_tags (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .bus         (bus),
      .hold_i      (msi_req_o),
      .image_o     (tag_image),
      .pending_o   (tag_pending),
      .eff_part_o  (eff_part),
      .eff_group_o (eff_group)
   );

   // ****************************************************************
   // enable and its acknowledge
   // ****************************************************************
   logic raise_done;
   logic drop_ok;
   assign raise_done = enable_reg && !ack_reg;
   // the ack may fall only when every earlier write has completed
   assign drop_ok = !enable_reg && ack_reg && outst_reg == '0 && !msi_req_o;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         enable_reg <= msi_cfg_pkg::ENABLE_RST;
      end else if (reg_wr_i && reg_addr_i == msi_cfg_pkg::CTRL_OFS) begin
         enable_reg <= reg_wdata_i[msi_cfg_pkg::ENABLE_BIT];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ack_reg <= msi_cfg_pkg::ENABLE_RST;
      end else if (raise_done) begin
         ack_reg <= 1'b1;
      end else if (drop_ok) begin
         ack_reg <= 1'b0;
      end
   end

   // ****************************************************************
   // abort flag: a new abort wins over the clear on enable
   // ****************************************************************
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         abort_reg <= 1'b0;
      end else if (msi_done_i && msi_abort_i && MSI_SUPPORTED) begin
         abort_reg <= 1'b1;
      end else if (raise_done) begin
         abort_reg <= 1'b0;
      end
   end

   // ****************************************************************
   // interrupt pending and launch
   // ****************************************************************
   logic raw_irq;
   logic fire;
   logic tgt_zero;
   logic sel_ns;
   logic part_ok;
   logic group_ok;
   logic is_device;
   assign raw_irq = |(overflow_flag_i & counter_int_enable_i)
                    && enable_reg && ack_reg;
   assign fire = pending_reg && enable_reg && ack_reg && !msi_req_o
                 && outst_reg != OUT_MAX;
   assign tgt_zero = {tgt_hi, tgt_lo} == 64'h0;
   assign sel_ns = msi_nonsecure_select_i | nonsecure_reg_access_i;
   assign part_ok = eff_part <= (sel_ns ? NS_PARTITION_LIMIT : S_PARTITION_LIMIT);
   assign group_ok = eff_group <= (sel_ns ? NS_GROUP_LIMIT : S_GROUP_LIMIT);
   assign is_device = (attr[msi_cfg_pkg::KIND_LSB +: 4] & msi_cfg_pkg::DEV_KIND_MASK)
                      == msi_cfg_pkg::DEV_KIND_VAL;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pending_reg <= 1'b0;
      end else begin
         pending_reg <= raw_irq | (pending_reg & ~fire);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         irq_edge_o <= 1'b0;
      end else begin
         irq_edge_o <= fire && (tgt_zero || !MSI_SUPPORTED);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         msi_req_o <= 1'b0;
      end else if (fire && !tgt_zero && MSI_SUPPORTED) begin
         msi_req_o <= 1'b1;
      end else if (msi_ack_i) begin
         msi_req_o <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         outst_reg <= '0;
      end else if ((msi_req_o && msi_ack_i) && !msi_done_i) begin
         outst_reg <= outst_reg + CW'(1);
      end else if (!(msi_req_o && msi_ack_i) && msi_done_i && outst_reg != '0) begin
         outst_reg <= outst_reg - CW'(1);
      end
   end

   // attributes captured at launch so they stand for the whole handshake
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         msi_addr_o      <= 64'h0;
         msi_data_o      <= 32'h0;
         msi_domain_o    <= msi_cfg_pkg::DOM_NONSH;
         msi_kind_o      <= 4'h0;
         msi_ns_o        <= 1'b0;
         msi_partition_o <= msi_cfg_pkg::PART_RST;
         msi_group_o     <= msi_cfg_pkg::GROUP_RST;
      end else if (fire && !tgt_zero) begin
         msi_addr_o      <= {tgt_hi, tgt_lo};
         msi_data_o      <= payload;
         msi_kind_o      <= attr[msi_cfg_pkg::KIND_LSB +: 4];
         msi_ns_o        <= sel_ns;
         // over-limit identifiers are sent as zero
         msi_partition_o <= part_ok ? eff_part : 16'h0000;
         msi_group_o     <= group_ok ? eff_group : 8'h00;
         if (is_device) begin
            msi_domain_o <= msi_cfg_pkg::DOM_OUTER;
         end else if (attr[msi_cfg_pkg::DOMAIN_LSB +: 2] == msi_cfg_pkg::DOM_RSVD) begin
            msi_domain_o <= msi_cfg_pkg::DOM_NONSH;
         end else begin
            msi_domain_o <= attr[msi_cfg_pkg::DOMAIN_LSB +: 2];
         end
      end
   end

   // ****************************************************************
   // read port
   // ****************************************************************
   logic [31:0] rd_next;
   always_comb begin
      rd_next = 32'h0;
      case (reg_addr_i)
         msi_cfg_pkg::CTRL_OFS:    rd_next = {31'h0, enable_reg};
         msi_cfg_pkg::ACK_OFS:     rd_next = {31'h0, ack_reg};
         msi_cfg_pkg::TGT_LO_OFS:  rd_next = tgt_lo;
         msi_cfg_pkg::TGT_HI_OFS:  rd_next = tgt_hi;
         msi_cfg_pkg::PAYLOAD_OFS: rd_next = payload;
         msi_cfg_pkg::ATTR_OFS:    rd_next = attr;
         msi_cfg_pkg::STATUS_OFS:  rd_next = {31'h0, abort_reg & MSI_SUPPORTED};
         msi_cfg_pkg::TAGS_OFS:    rd_next = tag_image;
         default:                  rd_next = 32'h0;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         reg_rdata_o  <= 32'h0;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rdata_o  <= reg_rd_i ? rd_next : 32'h0;
         reg_rvalid_o <= reg_rd_i;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   lock_hold_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      (reg_wr_i && reg_addr_i == msi_cfg_pkg::PAYLOAD_OFS && lock) |=> $stable(payload))
      else $error("locked payload changed");

   zero_target_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      $rose(msi_req_o) |-> msi_addr_o != 64'h0 && !irq_edge_o)
      else $error("write issued to zero target");

   abort_clear_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      (raise_done && !(msi_done_i && msi_abort_i)) |=> !abort_reg)
      else $error("abort not cleared on enable");

   abort_keep_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      ($fell(enable_reg) && abort_reg) |-> ##1 abort_reg [*2])
      else $error("abort lost on disable");

   device_dom_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      ($rose(msi_req_o) && $past(is_device)) |-> msi_domain_o == msi_cfg_pkg::DOM_OUTER)
      else $error("device write not outer domain");

   rsvd_dom_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      $rose(msi_req_o) |-> msi_domain_o != msi_cfg_pkg::DOM_RSVD)
      else $error("reserved domain code issued");

   quiet_off_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      !ack_reg |=> !$rose(msi_req_o) && !irq_edge_o)
      else $error("interrupt after disable completed");

   drop_wait_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      $fell(ack_reg) |-> $past(outst_reg) == '0 && !$past(msi_req_o))
      else $error("disable completed with writes outstanding");

   irq_gate_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      ($rose(msi_req_o) || irq_edge_o) |-> $past(enable_reg) && $past(ack_reg))
      else $error("interrupt while disabled");
endmodule : perf_monitor_msi_config

/* rtl/msi_cfg_pkg.sv */
package msi_cfg_pkg;

   // ****************************************************************
   // register offsets, byte addresses on the register port
   // ****************************************************************
   localparam logic [11:0] CTRL_OFS    = 12'he50;
   localparam logic [11:0] ACK_OFS     = 12'he54;
   localparam logic [11:0] TGT_LO_OFS  = 12'he58;
   localparam logic [11:0] TGT_HI_OFS  = 12'he5c;
   localparam logic [11:0] PAYLOAD_OFS = 12'he60;
   localparam logic [11:0] ATTR_OFS    = 12'he64;
   localparam logic [11:0] STATUS_OFS  = 12'he68;
   localparam logic [11:0] TAGS_OFS    = 12'he6c;

   // ****************************************************************
   // field positions and masks
   // ****************************************************************
   localparam int          ENABLE_BIT     = 0;
   localparam int          ABORT_BIT      = 0;
   localparam int          UPDATE_BIT     = 31;
   localparam int          GROUP_LSB      = 16;
   localparam int          PART_LSB       = 0;
   localparam int          DOMAIN_LSB     = 4;
   localparam int          KIND_LSB       = 0;
   localparam logic [63:0] ADDR_FIELD     = 64'h000f_ffff_ffff_fffc;
   localparam logic [31:0] ATTR_MASK      = 32'h0000_003f;
   localparam logic [31:0] PAYLOAD_MASK   = 32'hffff_ffff;

   // ****************************************************************
   // encodings
   // ****************************************************************
   localparam logic [1:0]  DOM_NONSH      = 2'h0;
   localparam logic [1:0]  DOM_RSVD       = 2'h1;
   localparam logic [1:0]  DOM_OUTER      = 2'h2;
   localparam logic [3:0]  DEV_KIND_MASK  = 4'hc;
   localparam logic [3:0]  DEV_KIND_VAL   = 4'h0;

   // ****************************************************************
   // values after reset
   // ****************************************************************
   localparam logic        ENABLE_RST     = 1'h0;
   localparam logic        UPDATE_RST     = 1'h0;
   localparam logic [7:0]  GROUP_RST      = 8'h00;
   localparam logic [15:0] PART_RST       = 16'h0000;

   // identifier width: position of the top one plus one, zero for zero
   function automatic logic [15:0] id_mask(input logic [15:0] lim);
      logic [15:0] m;
      m = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         if (lim[i]) begin
            m = 16'(({17'h0, 16'h0} | 17'h1) << (i + 1)) - 16'h1;
            if (i == 15) begin
               m = 16'hffff;
            end
         end
      end
      return m;
   endfunction : id_mask

endpackage : msi_cfg_pkg

/* rtl/cfg_write_if.sv */
`timescale 1ns/1ns
interface cfg_write_if;
   logic        wr;
   logic [11:0] addr;
   logic [31:0] wdata;

   modport master (output wr, output addr, output wdata);
   modport target (input wr, input addr, input wdata);
endinterface : cfg_write_if

/* rtl/guarded_word.sv */
`timescale 1ns/1ns
module guarded_word #(
   parameter logic [11:0] OFFSET    = 12'h000,
   parameter logic [31:0] KEEP_MASK = 32'hffff_ffff,
   parameter bit          PRESENT   = 1'b1
) (
   input  wire logic        ref_clk_i,
   cfg_write_if.target      bus,
   input  wire logic        lock_i,
   output logic [31:0]      value_o
);
   logic [31:0] word_reg;

   // ****************************************************************
   // storage: deliberately no reset, software programs it first
   // ****************************************************************
   always_ff @(posedge ref_clk_i) begin
      if (bus.wr && bus.addr == OFFSET && !lock_i && PRESENT) begin
         word_reg <= bus.wdata & KEEP_MASK;
      end
   end

   assign value_o = PRESENT ? (word_reg & KEEP_MASK) : 32'h0;
endmodule : guarded_word

/* rtl/msi_tag_update.sv */
`timescale 1ns/1ns
module msi_tag_update #(
   parameter logic [15:0] PART_MASK  = 16'hffff,
   parameter logic [7:0]  GROUP_MASK = 8'hff
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   cfg_write_if.target      bus,
   input  wire logic        hold_i,
   output logic [31:0]      image_o,
   output logic             pending_o,
   output logic [15:0]      eff_part_o,
   output logic [7:0]       eff_group_o
);
   logic [15:0] part_reg;
   logic [7:0]  group_reg;
   logic        pending_reg;
   logic        accept;

   // writes without the update flag, or during an update, are ignored
   assign accept = bus.wr && bus.addr == msi_cfg_pkg::TAGS_OFS
                   && bus.wdata[msi_cfg_pkg::UPDATE_BIT] && !pending_reg;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         part_reg  <= msi_cfg_pkg::PART_RST;
         group_reg <= msi_cfg_pkg::GROUP_RST;
      end else if (accept) begin
         part_reg  <= bus.wdata[msi_cfg_pkg::PART_LSB +: 16] & PART_MASK;
         group_reg <= bus.wdata[msi_cfg_pkg::GROUP_LSB +: 8] & GROUP_MASK;
      end
   end

   // ****************************************************************
   // update flag: completes once no write is in the handshake
   // ****************************************************************
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pending_reg <= msi_cfg_pkg::UPDATE_RST;
      end else if (accept) begin
         pending_reg <= 1'b1;
      end else if (pending_reg && !hold_i) begin
         pending_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         eff_part_o  <= msi_cfg_pkg::PART_RST;
         eff_group_o <= msi_cfg_pkg::GROUP_RST;
      end else if (pending_reg && !hold_i) begin
         eff_part_o  <= part_reg;
         eff_group_o <= group_reg;
      end
   end

   assign pending_o = pending_reg;
   assign image_o   = {pending_reg, 7'h00, group_reg, part_reg};

   update_done_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      (pending_reg && !hold_i) |=> !pending_reg && eff_part_o == $past(part_reg))
      else $error("tag update did not complete with stored value");

   readback_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      accept |=> pending_reg && part_reg == ($past(bus.wdata[15:0]) & PART_MASK))
      else $error("accepted tag write not visible on read");
endmodule : msi_tag_update

/* sim/msi_sink.sv */
`timescale 1ns/1ns
module msi_sink (
   input  wire logic ref_clk_i,
   input  wire logic req_i,
   input  wire logic abort_cmd_i,
   output logic      ack_o,
   output logic      done_o,
   output logic      abort_o
);
   // one idle cycle before accepting, so requests must stand
   initial begin
      ack_o = 1'b0;
      done_o = 1'b0;
      abort_o = 1'b0;
   end
   always @(posedge ref_clk_i) begin
      ack_o   <= #10 req_i & ~ack_o;
      done_o  <= #10 ack_o;
      abort_o <= #10 ack_o & abort_cmd_i;
   end
endmodule : msi_sink

/* sim/perf_monitor_msi_config_tb_top.sv */
`timescale 1ns/1ns
module perf_monitor_msi_config_tb_top;
   logic clk, rst, wr, rd, rv, req, ack, dn, ab, abc, ns, edg, mns;
   logic [11:0] ad;
   logic [31:0] wd, rdt, mdat, q;
   logic [63:0] madr;
   logic [3:0] ovf, ien, kind;
   logic [1:0] dom;
   logic [15:0] part;
   logic [7:0] grp;
   int n_mismatch, n_compared, cyc;
   perf_monitor_msi_config u_dut (.ref_clk_i(clk), .rst_i(rst), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_addr_i(ad), .reg_wdata_i(wd), .reg_rdata_o(rdt),
      .reg_rvalid_o(rv), .overflow_flag_i(ovf), .counter_int_enable_i(ien),
      .msi_nonsecure_select_i(ns), .nonsecure_reg_access_i(1'b0), .msi_req_o(req),
      .msi_addr_o(madr), .msi_data_o(mdat), .msi_domain_o(dom), .msi_kind_o(kind),
      .msi_ns_o(mns), .msi_partition_o(part), .msi_group_o(grp), .msi_ack_i(ack),
      .msi_done_i(dn), .msi_abort_i(ab), .irq_edge_o(edg));
   msi_sink u_sink (.ref_clk_i(clk), .req_i(req), .abort_cmd_i(abc), .ack_o(ack),
      .done_o(dn), .abort_o(ab));
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task chk(input string n, input logic [63:0] e, input logic [63:0] g);
      n_compared++;
      if (g !== e) begin
         $display("ERROR %s exp %h got %h", n, e, g);
         n_mismatch++;
      end
   endtask : chk
   task wrr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      #10 wr = 1'b1; ad = a; wd = d;
      @(posedge clk);
      #10 wr = 1'b0;
   endtask : wrr
   task rdc(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      #10 rd = 1'b1; ad = a;
      @(posedge clk);
      #10 rd = 1'b0;
      chk("rvalid", 64'h1, {63'h0, rv});
      chk("rdata", {32'h0, e}, {32'h0, rdt});
   endtask : rdc
   // read issued the cycle after the write, while the update flag still stands
   task wrrd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
      @(posedge clk);
      #10 wr = 1'b1; ad = a; wd = d;
      @(posedge clk);
      #10 wr = 1'b0; rd = 1'b1;
      @(posedge clk);
      #10 rd = 1'b0;
      chk("rvalid", 64'h1, {63'h0, rv});
      chk("rdata", {32'h0, e}, {32'h0, rdt});
   endtask : wrrd
   task fire(output logic m, output logic w);
      @(posedge clk);
      #10 ovf = 4'h1;
      @(posedge clk);
      #10 ovf = 4'h0;
      m = 1'b0;
      w = 1'b0;
      repeat (6) begin
         @(posedge clk);
         #10 m = m | req;
         w = w | edg;
      end
   endtask : fire
   task wrap_up;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task t_cfg;
      rdc(12'he6c, 32'h0000_0000);
      rdc(12'he68, 32'h0000_0000);
      wrr(12'he58, 32'h1234_5677);
      wrr(12'he5c, 32'hfff0_0abc);
      wrr(12'he60, 32'hcafe_0001);
      wrr(12'he64, 32'hffff_ff31);
      rdc(12'he58, 32'h1234_5674);
      rdc(12'he5c, 32'h0000_0abc);
      rdc(12'he64, 32'h0000_0031);
      wrr(12'he68, 32'h0000_0001);
      rdc(12'he68, 32'h0000_0000);
   endtask : t_cfg
   task t_tags;
      wrrd(12'he6c, 32'h8012_0034, 32'h8012_0034);
      rdc(12'he6c, 32'h0012_0034);
      wrr(12'he6c, 32'h0000_0055);
      rdc(12'he6c, 32'h0012_0034);
   endtask : t_tags
   task t_msi;
      logic m, w;
      wrr(12'he50, 32'h0000_0001);
      rdc(12'he54, 32'h0000_0001);
      wrr(12'he60, 32'h0bad_0bad);
      rdc(12'he60, 32'hcafe_0001);
      abc = 1'b1;
      fork
         fire(m, w);
         begin
            wait (req === 1'b1);
            #10 chk("addr", 64'h0000_0abc_1234_5674, madr);
            chk("data", {32'h0, 32'hcafe_0001}, {32'h0, mdat});
            chk("dom", 64'h2, {62'h0, dom});
            chk("kind", 64'h1, {60'h0, kind});
            chk("part", 64'h34, {48'h0, part});
            chk("grp", 64'h12, {56'h0, grp});
            chk("ns", 64'h1, {63'h0, mns});
         end
      join
      chk("req", 64'h1, {63'h0, m});
      rdc(12'he68, 32'h0000_0001);
      abc = 1'b0;
      wrr(12'he50, 32'h0000_0000);
      rdc(12'he68, 32'h0000_0001);
      wrr(12'he50, 32'h0000_0001);
      rdc(12'he68, 32'h0000_0000);
   endtask : t_msi
   task t_zero;
      logic m, w;
      ien = 4'h0;
      fire(m, w);
      chk("masked", 64'h0, {62'h0, m, w});
      ien = 4'h1;
      wrr(12'he50, 32'h0000_0000);
      repeat (4) @(posedge clk);
      wrr(12'he58, 32'h0000_0000);
      wrr(12'he5c, 32'h0000_0000);
      rdc(12'he58, 32'h0000_0000);
      wrr(12'he50, 32'h0000_0001);
      fire(m, w);
      chk("zero", 64'h1, {62'h0, m, w});
   endtask : t_zero
   // ****************************************************************
   // clock, reset, run
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         wrap_up;
      end
   end
   initial begin
      {rst, wr, rd, abc, ns, ad, wd, ovf} = '0;
      ien = 4'h1;
      rst = 1'b1;
      ns = 1'b1;
      repeat (20) @(posedge clk);
      #10 rst = 1'b0;
      t_cfg;
      t_tags;
      t_msi;
      t_zero;
      wrap_up;
   end
endmodule : perf_monitor_msi_config_tb_top
